// File: core/ts_capture_map.svh
// Register map and field constants for the frame timestamp capture unit
// Summary of operation
// [RQ1] Timestamping works only while the precise-time enable bit is one.
// [RQ2] Client logic flags each event frame with the event-frame flag alongside the frame.
// [RQ3] Every sent frame returns a 32-bit capture, a 4-bit sequence tag and a status word.
// [RQ4] Status bit 5 is set when the frame carried the event-frame flag.
// [RQ5] A flagged frame's capture is also stored in the held transmit-capture register.
// [RQ6] Storing a held capture sets the capture-ready bit in the event register.
// [RQ7] Software flags a frame, waits for capture-ready, then reads the held capture.
// [RQ8] Unflagged frames never touch the held capture or the capture-ready bit.
// [RQ9] Every received frame latches the timer at delimiter detection as its receive capture.
// [RQ10] The receive DMA copies the receive capture into the frame's descriptor.
// [RQ11] The interrupt request rises only for event bits whose mask bit is set.
// [RQ12] Event bits clear on writing one, ignore zero, and reset to zero.
// [RQ13] The sequence tag advances by one per sent frame and wraps from fifteen to zero.
// [RQ14] The receive capture holds stable until the frame end is delivered.
`ifndef TS_CAPTURE_MAP_SVH
`define TS_CAPTURE_MAP_SVH
`define REG_IRQ_EVENT 8'h04
`define REG_IRQ_MASK 8'h08
`define REG_CONTROL 8'h10
`define REG_HELD_CAPTURE 8'h14
`define REG_SEQ_STATUS 8'h18
`define CTRL_ENABLE_BIT 0
`define EVT_CAPTURE_READY_BIT 0
`define EVT_TIMER_WRAP_BIT 1
`define EVT_WIDTH 2
`define TX_STAT_FLAG_BIT 5
`define TX_STAT_WIDTH 8
`define RESET_WORD 32'h0000_0000
`endif

// File: core/ts_capture_pkg.sv
// Types shared by the frame timestamp capture unit
package ts_capture_pkg;
  typedef struct packed {
    logic valid;
    logic [31:0] value;
    logic [3:0] seq_tag;
    logic [7:0] status;
  } tx_capture_t;
  typedef struct packed {
    logic valid;
    logic [31:0] value;
  } rx_capture_t;
  typedef enum logic [1:0] {
    rx_idle,
    rx_in_frame
  } rx_state_t;
endpackage

// File: core/ts_hold_reg.sv
// Loadable holding register with reset and clock enable
`timescale 1ns/10ps
module ts_hold_reg #(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] next_dout;

  initial begin
    if (WIDTH < 1) $error("ts_hold_reg width must be positive");
  end

  always_comb begin
    next_dout = load ? din : dout;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dout <= '0;
    end else if (clk_en) begin
      dout <= next_dout;
    end
  end
endmodule

// File: core/frame_timestamp_capture.sv
// Frame timestamp capture unit: transmit and receive capture with register port
`timescale 1ns/10ps
`include "ts_capture_map.svh"
module frame_timestamp_capture #(
  parameter int TS_WIDTH = 32,
  parameter int SEQ_WIDTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [31:0] timer_value,
  input wire logic timer_wrap_event,
  input wire logic tx_frame_done,
  input wire logic tx_event_frame_flag,
  input wire logic [TS_WIDTH-1:0] tx_frame_timer,
  input wire logic [`TX_STAT_WIDTH-1:0] tx_frame_status,
  output ts_capture_pkg::tx_capture_t tx_capture,
  input wire logic rx_sfd_detect,
  input wire logic rx_frame_end,
  output ts_capture_pkg::rx_capture_t rx_capture,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq
);
  import ts_capture_pkg::*;

  initial begin
    if (TS_WIDTH != 32) $error("TS_WIDTH must be 32");
    if (SEQ_WIDTH != 4) $error("SEQ_WIDTH must be 4");
  end

  logic precise_time_enable;
  logic next_enable;
  logic [`EVT_WIDTH-1:0] irq_event_reg;
  logic [`EVT_WIDTH-1:0] next_event;
  logic [`EVT_WIDTH-1:0] irq_mask_reg;
  logic [`EVT_WIDTH-1:0] next_mask;
  logic [31:0] next_rdata;
  logic [SEQ_WIDTH-1:0] tx_frame_seq_tag;
  logic [SEQ_WIDTH-1:0] next_seq;
  tx_capture_t next_tx;
  rx_capture_t next_rx;
  rx_state_t rx_state;
  rx_state_t next_rx_state;
  logic [31:0] held_tx_capture;
  logic tx_done_on;
  logic hold_load;

  assign tx_done_on = tx_frame_done && precise_time_enable;
  // [RQ5] [RQ8] Only flagged frames load
  assign hold_load = tx_done_on && tx_event_frame_flag;

  ts_hold_reg #(
    .WIDTH(TS_WIDTH)
  ) u_held (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .load(hold_load),
    .din(tx_frame_timer),
    .dout(held_tx_capture)
  );

  // Register group: control, mask, event bits
  always_comb begin
    next_enable = precise_time_enable;
    next_mask = irq_mask_reg;
    next_event = irq_event_reg;
    if (reg_write && reg_addr == `REG_CONTROL) begin
      next_enable = reg_wdata[`CTRL_ENABLE_BIT];
    end else if (reg_write && reg_addr == `REG_IRQ_MASK) begin
      next_mask = reg_wdata[`EVT_WIDTH-1:0];
    end else if (reg_write && reg_addr == `REG_IRQ_EVENT) begin
      // [RQ12] Write one to clear
      next_event = irq_event_reg & ~reg_wdata[`EVT_WIDTH-1:0];
    end
    // [RQ6] Capture ready; set beats clear
    if (hold_load) begin
      next_event[`EVT_CAPTURE_READY_BIT] = 1'b1;
    end
    if (timer_wrap_event && precise_time_enable) begin
      next_event[`EVT_TIMER_WRAP_BIT] = 1'b1;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_comb begin
    next_rdata = `RESET_WORD;
    if (reg_read) begin
      if (reg_addr == `REG_IRQ_EVENT) begin
        next_rdata = {{(32-`EVT_WIDTH){1'b0}}, irq_event_reg};
      end else if (reg_addr == `REG_IRQ_MASK) begin
        next_rdata = {{(32-`EVT_WIDTH){1'b0}}, irq_mask_reg};
      end else if (reg_addr == `REG_CONTROL) begin
        next_rdata = {31'h0000_0000, precise_time_enable};
      end else if (reg_addr == `REG_HELD_CAPTURE) begin
        next_rdata = held_tx_capture;
      end else if (reg_addr == `REG_SEQ_STATUS) begin
        next_rdata = {28'h000_0000, tx_frame_seq_tag};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      precise_time_enable <= 1'b0;
      irq_mask_reg <= '0;
      irq_event_reg <= '0;
      reg_rdata <= `RESET_WORD;
    end else if (clk_en) begin
      precise_time_enable <= next_enable;
      irq_mask_reg <= next_mask;
      irq_event_reg <= next_event;
      reg_rdata <= next_rdata;
    end
  end

  // [RQ11] Masked interrupt level
  assign irq = |(irq_event_reg & irq_mask_reg);

  // Transmit return path
  always_comb begin
    next_seq = tx_frame_seq_tag;
    next_tx = tx_capture;
    next_tx.valid = 1'b0;
    // [RQ1] [RQ3] Per-frame return
    if (tx_done_on) begin
      next_tx.valid = 1'b1;
      next_tx.value = tx_frame_timer;
      next_tx.seq_tag = tx_frame_seq_tag;
      next_tx.status = tx_frame_status;
      // [RQ4] Flag echo bit
      next_tx.status[`TX_STAT_FLAG_BIT] = tx_event_frame_flag;
      // [RQ13] Tag wraps naturally
      next_seq = tx_frame_seq_tag + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_capture <= '0;
      tx_frame_seq_tag <= '0;
    end else if (clk_en) begin
      tx_capture <= next_tx;
      tx_frame_seq_tag <= next_seq;
    end
  end

  // Receive capture machine
  always_comb begin
    next_rx_state = rx_state;
    next_rx = rx_capture;
    case (rx_state)
      rx_idle: begin
        // [RQ9] Latch at delimiter
        if (rx_sfd_detect && precise_time_enable) begin
          next_rx.value = timer_value;
          next_rx.valid = 1'b1;
          next_rx_state = rx_in_frame;
        end
      end
      rx_in_frame: begin
        // [RQ14] Hold until frame end
        if (rx_frame_end) begin
          next_rx.valid = 1'b0;
          next_rx_state = rx_idle;
        end
      end
      default: begin
        next_rx_state = rx_idle;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_state <= rx_idle;
      rx_capture <= '0;
    end else if (clk_en) begin
      rx_state <= next_rx_state;
      rx_capture <= next_rx;
    end
  end

  // Assertions
  property p_hold;
    @(posedge clk) disable iff (!reset_n)
      (clk_en && hold_load) |=> held_tx_capture == $past(tx_frame_timer);
  endproperty
  held_capture_load_a: assert property (p_hold) else $error("held capture not loaded"); // RQ5
  ready_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && hold_load) |=> irq_event_reg[`EVT_CAPTURE_READY_BIT]) // RQ6
    else $error("capture ready not set");
  unflagged_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && !hold_load) |=> $stable(held_tx_capture)) // RQ8
    else $error("held capture disturbed");
  tx_status_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && tx_done_on) |=> tx_capture.valid &&
      tx_capture.status[`TX_STAT_FLAG_BIT] == $past(tx_event_frame_flag)) // RQ4
    else $error("status flag bit wrong");
  disabled_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!precise_time_enable && clk_en) |=> !tx_capture.valid) // RQ1
    else $error("capture while disabled");
  seq_advance_a: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && tx_done_on) |=> tx_frame_seq_tag == $past(tx_frame_seq_tag) + 4'h1) // RQ13
    else $error("sequence tag did not advance");
  tx_value_a: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && tx_done_on) |=> tx_capture.value == $past(tx_frame_timer)) // RQ3
    else $error("returned capture wrong");
  rx_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && rx_state == rx_idle && rx_sfd_detect && precise_time_enable)
      |=> rx_capture.valid && rx_capture.value == $past(timer_value)) // RQ9
    else $error("receive capture not latched");
  rx_stable_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rx_state == rx_in_frame && !rx_frame_end) |=> $stable(rx_capture.value)) // RQ14
    else $error("receive capture moved in frame");
  irq_mask_a: assert property (@(posedge clk) disable iff (!reset_n)
    irq == |(irq_event_reg & irq_mask_reg) && (irq_mask_reg == '0 -> !irq)) // RQ11
    else $error("interrupt not masked");
  w1c_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && reg_write && reg_addr == `REG_IRQ_EVENT && reg_wdata[0] && !hold_load)
      |=> !irq_event_reg[`EVT_CAPTURE_READY_BIT]) // RQ12
    else $error("event bit not cleared");
  flagged_frame_c: cover property (@(posedge clk) clk_en && hold_load);
  rx_frame_c: cover property (@(posedge clk) rx_state == rx_in_frame && rx_frame_end);
  irq_raise_c: cover property (@(posedge clk) $rose(irq));
  seq_wrap_c: cover property (@(posedge clk) tx_done_on && tx_frame_seq_tag == 4'hf);
endmodule

// File: testbench/mac_client_model.sv
// MAC client and receive DMA stand-in facing the capture unit
`timescale 1ns/10ps
module mac_client_model (
  input wire logic clk,
  input ts_capture_pkg::rx_capture_t rx_capture,
  output logic [31:0] timer_value,
  output logic tx_frame_done,
  output logic tx_event_frame_flag,
  output logic [31:0] tx_frame_timer,
  output logic [7:0] tx_frame_status,
  output logic rx_sfd_detect,
  output logic rx_frame_end
);
  import ts_capture_pkg::*;
  logic [31:0] desc_ts;
  initial begin
    timer_value = 32'h0000_1000;
    tx_frame_done = 1'b0;
    tx_event_frame_flag = 1'b0;
    tx_frame_timer = 32'h0;
    tx_frame_status = 8'h0;
    rx_sfd_detect = 1'b0;
    rx_frame_end = 1'b0;
  end
  // Timer moves on the falling edge so it is settled at sampling
  always @(negedge clk) timer_value <= timer_value + 32'h0000_0101;
  task send(input logic flag, input logic [31:0] v, input logic [7:0] st);
    @(posedge clk);
    tx_frame_done <= 1'b1;
    tx_event_frame_flag <= flag;
    tx_frame_timer <= v;
    tx_frame_status <= st;
    @(posedge clk);
    tx_frame_done <= 1'b0;
    tx_event_frame_flag <= ~flag;
    tx_frame_timer <= ~v;
    tx_frame_status <= ~st;
    #1;
  endtask
  task sfd(output logic [31:0] v);
    @(posedge clk);
    rx_sfd_detect <= 1'b1;
    @(posedge clk);
    rx_sfd_detect <= 1'b0;
    v = timer_value;
    #1;
  endtask
  task frame_end;
    @(posedge clk);
    rx_frame_end <= 1'b1;
    @(posedge clk);
    rx_frame_end <= 1'b0;
    #1;
  endtask
  always @(posedge clk) if (rx_frame_end) desc_ts <= rx_capture.value;
endmodule

// File: testbench/frame_timestamp_capture_test.sv
// Self-checking bench for the frame timestamp capture unit
`timescale 1ns/10ps
`include "ts_capture_map.svh"
module frame_timestamp_capture_test;
  import ts_capture_pkg::*;
  logic clk, reset_n, clk_en, timer_wrap_event, reg_write, reg_read, irq;
  logic tx_frame_done, tx_event_frame_flag, rx_sfd_detect, rx_frame_end;
  logic [31:0] timer_value, tx_frame_timer, reg_wdata, reg_rdata, v, r;
  logic [7:0] tx_frame_status, reg_addr;
  tx_capture_t tx_capture;
  rx_capture_t rx_capture;
  int n_errors = 0;
  int check_count = 0;
  frame_timestamp_capture u_frame_timestamp_capture (.clk(clk), .reset_n(reset_n),
    .clk_en(clk_en), .timer_value(timer_value), .timer_wrap_event(timer_wrap_event),
    .tx_frame_done(tx_frame_done), .tx_event_frame_flag(tx_event_frame_flag),
    .tx_frame_timer(tx_frame_timer), .tx_frame_status(tx_frame_status),
    .tx_capture(tx_capture), .rx_sfd_detect(rx_sfd_detect), .rx_frame_end(rx_frame_end),
    .rx_capture(rx_capture), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));
  mac_client_model client (.clk(clk), .rx_capture(rx_capture), .timer_value(timer_value),
    .tx_frame_done(tx_frame_done), .tx_event_frame_flag(tx_event_frame_flag),
    .tx_frame_timer(tx_frame_timer), .tx_frame_status(tx_frame_status),
    .rx_sfd_detect(rx_sfd_detect), .rx_frame_end(rx_frame_end));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask
  task summarize;
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Whole run is about a hundred cycles
  initial begin
    #20000;
    n_errors++;
    summarize;
  end
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    timer_wrap_event = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rdc(`REG_IRQ_EVENT, 32'h0);
    rdc(8'h40, 32'h0);
    client.send(1'b1, 32'h1111_0000, 8'h00);
    check(tx_capture.valid, 32'h0);
    rdc(`REG_IRQ_EVENT, 32'h0);
    wr(`REG_CONTROL, 32'h1);
    client.send(1'b1, 32'hcafe_0001, 8'h00);
    check(tx_capture.valid, 32'h1);
    check(tx_capture.value, 32'hcafe_0001);
    check(tx_capture.seq_tag, 32'h0);
    check(tx_capture.status, 32'h20);
    rdc(`REG_IRQ_EVENT, 32'h1);
    rdc(`REG_HELD_CAPTURE, 32'hcafe_0001);
    check(irq, 32'h0);
    wr(`REG_IRQ_EVENT, 32'h0);
    rdc(`REG_IRQ_EVENT, 32'h1);
    wr(`REG_IRQ_EVENT, 32'h1);
    rdc(`REG_IRQ_EVENT, 32'h0);
    client.send(1'b0, 32'h0bad_0002, 8'hff);
    check(tx_capture.status, 32'hdf);
    check(tx_capture.seq_tag, 32'h1);
    rdc(`REG_HELD_CAPTURE, 32'hcafe_0001);
    rdc(`REG_IRQ_EVENT, 32'h0);
    client.send(1'b1, 32'h0000_0003, 8'h00);
    wr(`REG_IRQ_MASK, 32'h2);
    check(irq, 32'h0);
    wr(`REG_IRQ_MASK, 32'h1);
    check(irq, 32'h1);
    wr(`REG_IRQ_EVENT, 32'h1);
    check(irq, 32'h0);
    for (int i = 3; i < 17; i++) begin
      client.send(1'b0, 32'(i), 8'h00);
    end
    check(tx_capture.seq_tag, 32'h0);
    @(posedge clk);
    timer_wrap_event <= 1'b1;
    @(posedge clk);
    timer_wrap_event <= 1'b0;
    rdc(`REG_IRQ_EVENT, 32'h2);
    @(posedge clk);
    clk_en <= 1'b0;
    client.send(1'b1, 32'h5555_0005, 8'h00);
    check(tx_capture.valid, 32'h0);
    @(posedge clk);
    clk_en <= 1'b1;
    rdc(`REG_SEQ_STATUS, 32'h1);
    rdc(`REG_HELD_CAPTURE, 32'h0000_0003);
    client.sfd(v);
    repeat (3) @(posedge clk);
    #1;
    check(rx_capture.valid, 32'h1);
    check(rx_capture.value, v);
    client.sfd(r);
    check(rx_capture.value, v);
    client.frame_end;
    check(rx_capture.valid, 32'h0);
    check(client.desc_ts, v);
    summarize;
  end
endmodule
